/* File: logic/kwrc_watchdog.sv */
// Keyed one-time-enabled watchdog with reset-out pulse.
// Assumes SFR strobes synchronous to clock_in; machine_cycle_in marks machine cycles.
//
// Contract
// - Key 1Eh then E1h enables watchdog
// - Same key sequence restarts counter at zero
// - 14-bit counter overflow at 3FFFh resets device
// - Count each machine cycle while oscillator runs
// - Key register write only; reads harmless
// - Counter neither readable nor loadable
// - Overflow drives 98-period reset pulse out
// - Disabled after any reset
// - Stays enabled until reset or overflow
`timescale 1ns/1ps
module kwrc_watchdog
   import kwrc_pkg::*;
(
   input wire logic clock_in,
   input wire logic reset_in,
   input wire logic clock_enable_in,
   input wire logic machine_cycle_in,
   input wire logic osc_running_in,
   input wire kwrc_sfr_t sfr_in,
   output logic [7:0] sfr_rdata_out,
   output logic enabled_out,
   output logic device_reset_out,
   output logic reset_pin_out
);
   kwrc_key_t key_q, key_d;
   logic enabled_q, enabled_d;
   logic [KWRC_CNT_W-1:0] count_q, count_d;
   logic [6:0] pulse_q, pulse_d;
   logic pin_q, pin_d;
   logic ovf_q;

   wire key_wr = sfr_in.wr && (sfr_in.addr == KWRC_KEY_ADDR);
   wire first_ok = key_wr && (sfr_in.wdata == KWRC_KEY_FIRST);
   wire second_ok = key_wr && (sfr_in.wdata == KWRC_KEY_SECOND) && (key_q == KWRC_GOT_FIRST);
   wire tick = enabled_q && machine_cycle_in && osc_running_in;
   wire overflow = enabled_q && (count_q == KWRC_CNT_TERM);

   // Reads of the key address return zero and touch no state
   assign sfr_rdata_out = 8'h00;
   assign enabled_out = enabled_q;
   assign device_reset_out = ovf_q;
   assign reset_pin_out = pin_q;

   always_comb begin
      key_d = key_q;
      if (key_wr) begin
         key_d = first_ok ? KWRC_GOT_FIRST : KWRC_IDLE;
      end
   end

   // Overflow clears enable, count and key state as reset does, and loads the reset pulse
   assign enabled_d = overflow ? 1'b0 : (enabled_q | second_ok);
   assign count_d = (overflow || second_ok) ? KWRC_CNT_ZERO :
      (tick ? count_q + KWRC_CNT_ONE : count_q);
   assign pulse_d = overflow ? KWRC_PULSE_LAST :
      ((pulse_q != KWRC_PULSE_ZERO) ? pulse_q - KWRC_PULSE_ONE : KWRC_PULSE_ZERO);
   assign pin_d = overflow || (pulse_q != KWRC_PULSE_ZERO);

   always_ff @(posedge clock_in or posedge reset_in) begin
      if (reset_in) begin
         key_q <= KWRC_IDLE;
         enabled_q <= 1'b0;
         count_q <= KWRC_CNT_ZERO;
         pulse_q <= KWRC_PULSE_ZERO;
         pin_q <= 1'b0;
         ovf_q <= 1'b0;
      end else if (clock_enable_in) begin
         key_q <= overflow ? KWRC_IDLE : key_d;
         enabled_q <= enabled_d;
         count_q <= count_d;
         pulse_q <= pulse_d;
         pin_q <= pin_d;
         ovf_q <= overflow;
      end
   end

   logic [7:0] hi_cnt_q;
   always_ff @(posedge clock_in or posedge reset_in) begin
      if (reset_in) begin
         hi_cnt_q <= 8'h00;
      end else if (clock_enable_in) begin
         hi_cnt_q <= pin_q ? hi_cnt_q + 8'h01 : 8'h00;
      end
   end

   enable_seq_a: assert property (@(posedge clock_in) disable iff (reset_in)
      clock_enable_in && second_ok && !overflow |=> enabled_q)
      else $error("key sequence did not enable");
   restart_zero_a: assert property (@(posedge clock_in) disable iff (reset_in)
      clock_enable_in && enabled_q && second_ok |=> count_q == KWRC_CNT_ZERO)
      else $error("restart did not clear counter");
   overflow_reset_a: assert property (@(posedge clock_in) disable iff (reset_in)
      clock_enable_in && enabled_q && count_q == KWRC_CNT_TERM |=> device_reset_out && !enabled_q)
      else $error("overflow did not reset");
   count_step_a: assert property (@(posedge clock_in) disable iff (reset_in)
      clock_enable_in && tick && !second_ok && !overflow |=> count_q == $past(count_q) + 14'h0001)
      else $error("counter did not advance");
   count_hold_a: assert property (@(posedge clock_in) disable iff (reset_in)
      clock_enable_in && !osc_running_in && !second_ok && !overflow |=> $stable(count_q))
      else $error("counter moved with oscillator stopped");
   read_zero_a: assert property (@(posedge clock_in) disable iff (reset_in)
      sfr_rdata_out == 8'h00)
      else $error("read returned data");
   pulse_len_a: assert property (@(posedge clock_in) disable iff (reset_in)
      $rose(pin_q) && clock_enable_in |-> ##97 (hi_cnt_q == 8'd97 || !clock_enable_in))
      else $error("reset pulse length wrong");
   stay_on_a: assert property (@(posedge clock_in) disable iff (reset_in)
      enabled_q && !overflow && clock_enable_in |=> enabled_q)
      else $error("watchdog disabled without reset");
   bad_byte_a: assert property (@(posedge clock_in) disable iff (reset_in)
      clock_enable_in && key_wr && !first_ok |=> key_q == KWRC_IDLE)
      else $error("partial key not abandoned");

   // Pulse shape checks; the pin must also fall on time, not only rise
   pulse_end_a: assert property (@(posedge clock_in) disable iff (reset_in)
      clock_enable_in && pin_q && pulse_q == KWRC_PULSE_ZERO && !overflow |=> !pin_q)
      else $error("reset pulse did not end");

   pulse_load_a: assert property (@(posedge clock_in) disable iff (reset_in)
      clock_enable_in && overflow |=> pulse_q == KWRC_PULSE_LAST && reset_pin_out)
      else $error("reset pulse not started");

   pin_idle_a: assert property (@(posedge clock_in) disable iff (reset_in)
      clock_enable_in && pulse_q == KWRC_PULSE_ZERO && !overflow |=> !pin_q)
      else $error("reset pin high without overflow");

   // Internal reset lasts one cycle; the block is already disabled in that same cycle
   dres_once_a: assert property (@(posedge clock_in) disable iff (reset_in)
      clock_enable_in && device_reset_out |=> !device_reset_out)
      else $error("device reset longer than one cycle");

   ovf_clear_a: assert property (@(posedge clock_in) disable iff (reset_in)
      clock_enable_in && overflow |=> key_q == KWRC_IDLE && count_q == KWRC_CNT_ZERO)
      else $error("overflow left state behind");

   // A disabled watchdog neither counts nor holds a stale count
   off_zero_a: assert property (@(posedge clock_in) disable iff (reset_in)
      !enabled_q |-> count_q == KWRC_CNT_ZERO && !tick)
      else $error("disabled watchdog counting");

   no_stray_on_a: assert property (@(posedge clock_in) disable iff (reset_in)
      clock_enable_in && !enabled_q && !second_ok |=> !enabled_q)
      else $error("enabled without full key");

   first_key_a: assert property (@(posedge clock_in) disable iff (reset_in)
      clock_enable_in && first_ok && !overflow |=> key_q == KWRC_GOT_FIRST)
      else $error("first key byte not taken");

   other_addr_a: assert property (@(posedge clock_in) disable iff (reset_in)
      clock_enable_in && !key_wr && !overflow |=> key_q == $past(key_q))
      else $error("key state moved without key write");

   // Reads must be side-effect free, or polling software could disturb the count
   read_quiet_a: assert property (@(posedge clock_in) disable iff (reset_in)
      clock_enable_in && sfr_in.rd && !sfr_in.wr && !tick && !overflow |=> $stable(count_q))
      else $error("read changed the counter");

   no_load_a: assert property (@(posedge clock_in) disable iff (reset_in)
      clock_enable_in && !tick && !second_ok && !overflow |=> $stable(count_q))
      else $error("counter loaded outside counting");

   freeze_a: assert property (@(posedge clock_in) disable iff (reset_in)
      !clock_enable_in |=> $stable(count_q) && $stable(enabled_q) && $stable(pulse_q))
      else $error("state moved with clock enable low");
endmodule

/* File: logic/kwrc_pkg.sv */
// Constants and carrier types for the keyed watchdog reset counter.
// Assumes a single 100 MHz clock that is also the oscillator clock.
package kwrc_pkg;
   localparam logic [7:0] KWRC_KEY_ADDR = 8'ha6;
   localparam logic [7:0] KWRC_KEY_FIRST = 8'h1e;
   localparam logic [7:0] KWRC_KEY_SECOND = 8'he1;
   localparam int KWRC_CNT_W = 14;
   localparam logic [13:0] KWRC_CNT_ZERO = 14'h0000;
   localparam logic [13:0] KWRC_CNT_ONE = 14'h0001;
   localparam logic [13:0] KWRC_CNT_TERM = 14'h3fff;
   // Pulse length in oscillator periods; one oscillator period is one clock cycle here
   localparam int KWRC_PULSE_OSC = 98;
   localparam int KWRC_PULSE_CYC = KWRC_PULSE_OSC;
   localparam logic [6:0] KWRC_PULSE_LAST = 7'(KWRC_PULSE_CYC - 1);
   localparam logic [6:0] KWRC_PULSE_ZERO = 7'h00;
   localparam logic [6:0] KWRC_PULSE_ONE = 7'h01;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } kwrc_sfr_t;

   typedef enum logic [1:0] {KWRC_IDLE, KWRC_GOT_FIRST} kwrc_key_t;
endpackage

/* File: test/kwrc_tb.sv */
// Bench for the keyed watchdog: key writes, restart, overflow and reset pulse.
// Assumes one tick per clock while machine cycle, clock enable and oscillator are high.
`timescale 1ns/1ps
module testbench;
   import kwrc_pkg::*;
   logic clock_in, reset_in, osc, en, dres, pin, ce, mc;
   logic [7:0] rdata;
   kwrc_sfr_t sfr;
   int mismatches, samples_checked, n;
   kwrc_watchdog dut (.clock_in(clock_in), .reset_in(reset_in), .clock_enable_in(ce),
      .machine_cycle_in(mc), .osc_running_in(osc), .sfr_in(sfr), .sfr_rdata_out(rdata),
      .enabled_out(en), .device_reset_out(dres), .reset_pin_out(pin));
   initial begin
      clock_in = 0;
      forever #5 clock_in = ~clock_in;
   end
   task stop_test();
      $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
      if (mismatches == 0 && samples_checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // One idle cycle after each write keeps strobe changes one per time step
   task wr(input logic [7:0] a, input logic [7:0] d);
      sfr = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clock_in);
      #1 sfr = '0;
      @(posedge clock_in);
      #1;
   endtask
   // Oscillator, machine cycle, then clock enable each low for hold clocks: no ticks
   // done is the count already reached when the task starts
   task ovf(input int hold, input int done);
      osc = 0;
      repeat (hold) @(posedge clock_in);
      #1 osc = 1;
      mc = 0;
      repeat (hold) @(posedge clock_in);
      #1 mc = 1;
      ce = 0;
      repeat (hold) @(posedge clock_in);
      #1 ce = 1;
      n = 3 * hold;
      while (dres !== 1'b1 && n < 40000) begin
         @(posedge clock_in);
         #1 n++;
      end
      chk("ticks to overflow", 16'(KWRC_CNT_TERM + 3 * hold + 1 - done), 16'(n));
      n = 0;
      while (pin === 1'b1 && n < 200) begin
         @(posedge clock_in);
         #1 n++;
      end
      chk("reset pin width", 16'(KWRC_PULSE_OSC), 16'(n));
      chk("enabled after overflow", 16'h0000, {15'h0000, en});
   endtask
   initial begin
      sfr = '0;
      osc = 1;
      ce = 1;
      mc = 1;
      reset_in = 1;
      repeat (2) @(posedge clock_in);
      #1 reset_in = 0;
      chk("enabled at reset", 16'h0000, {15'h0000, en});
      sfr = '{wr: 1'b0, rd: 1'b1, addr: KWRC_KEY_ADDR, wdata: 8'h00};
      #1 chk("key read", 16'h0000, {8'h00, rdata});
      @(posedge clock_in);
      #1;
      wr(KWRC_KEY_ADDR, KWRC_KEY_FIRST);
      wr(KWRC_KEY_ADDR, 8'h00);
      wr(KWRC_KEY_ADDR, KWRC_KEY_SECOND);
      chk("broken key", 16'h0000, {15'h0000, en});
      wr(KWRC_KEY_ADDR, KWRC_KEY_FIRST);
      wr(8'ha5, KWRC_KEY_SECOND);
      chk("key elsewhere", 16'h0000, {15'h0000, en});
      wr(KWRC_KEY_ADDR, KWRC_KEY_SECOND);
      chk("enabled", 16'h0001, {15'h0000, en});
      wr(KWRC_KEY_ADDR, 8'h00);
      chk("stays enabled", 16'h0001, {15'h0000, en});
      ovf(50, 3);
      wr(KWRC_KEY_ADDR, KWRC_KEY_FIRST);
      wr(KWRC_KEY_ADDR, KWRC_KEY_SECOND);
      repeat (9998) @(posedge clock_in);
      #1 wr(KWRC_KEY_ADDR, KWRC_KEY_FIRST);
      wr(KWRC_KEY_ADDR, KWRC_KEY_SECOND);
      ovf(0, 1);
      wr(KWRC_KEY_ADDR, KWRC_KEY_FIRST);
      wr(KWRC_KEY_ADDR, KWRC_KEY_SECOND);
      chk("enabled again", 16'h0001, {15'h0000, en});
      reset_in = 1;
      @(posedge clock_in);
      #1 reset_in = 0;
      chk("enabled after reset", 16'h0000, {15'h0000, en});
      stop_test();
   end
   initial begin
      #600000;
      mismatches++;
      stop_test();
   end
endmodule
